/* verilog/ofc_pkg.sv */
// Functional notes
// R1 - Main array: 128 pages, 8 rows, 256 bytes
// R2 - Info page: two rows, 512 bytes
// R3 - Eight 32 KB blocks, protected ones refuse writes
// R4 - Write-protect pin guards lowest block
// R5 - Memory reads need enable and wait count
// R6 - Info page only through the data port
// R7 - Every read gets automatic wait states
// R8 - Data port reads, then address auto-increments
// R9 - Data port byte write stalls 66 to 85 us
// R10 - Memory write programs one byte, stalls
// R11 - Row mode only with row enable set
// R12 - High voltage held until column 255 done
// R13 - Row mode byte takes 41 to 52 us
// R14 - Row time-out aborts and flags an error
// R15 - Host keeps row program time under 31 ms
// R16 - Host never reprograms a byte unerased
// R17 - Host row sequence: check, address, enable, write
// R18 - Erased bytes read FFh
// R19 - Erases self-timed, done bit on completion
// R20 - Array access stalls during erase
// R21 - Mass erase, info page only if selected
// R22 - Reads continue from other blocks while programming
// R23 - Page erase of selected page, about 10 ms
// R24 - Wait released the cycle after timer expiry
package ofc_pkg;
    // ****************************************
    // Geometry and timing
    // ****************************************
    localparam int PAGES          = 128;        // Main pages
    localparam int ROWS           = 8;          // Rows per page
    localparam int COLS           = 256;        // Bytes per row
    localparam int INFO_BYTES     = 512;        // Info page size
    localparam int PAGE_BYTES     = ROWS * COLS;
    localparam int MAIN_BYTES     = PAGES * PAGE_BYTES;
    localparam int CLK_PERIOD_NS  = 25;         // 40 MHz
    localparam int BYTE_PROG_NS   = 66000;      // Single byte program
    localparam int ROW_PROG_NS    = 41000;      // Row mode byte program
    localparam int PAGE_ERASE_MS  = 10;
    localparam int MASS_ERASE_MS  = 200;
    localparam int ROW_LIMIT_MS   = 31;         // Row time-out
    localparam int BYTE_PROG_CYC  = (BYTE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_PROG_CYC   = (ROW_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_ERASE_CYC = PAGE_ERASE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int MASS_ERASE_CYC = MASS_ERASE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int ROW_TMO_CYC    = ROW_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;  // Wait count, enable
    localparam logic [7:0] REG_PAGE   = 8'h04;  // Page select, info bit
    localparam logic [7:0] REG_ROW    = 8'h08;
    localparam logic [7:0] REG_COL    = 8'h0C;
    localparam logic [7:0] REG_DATA   = 8'h10;
    localparam logic [7:0] REG_PGCTL  = 8'h14;  // program_control_register
    localparam logic [7:0] REG_STAT   = 8'h18;
    localparam logic [7:0] REG_PROT   = 8'h1C;
    localparam logic [7:0] CTRL_RST   = 8'h88;  // Four waits, enabled
    localparam int CTRL_EN_BIT  = 3;
    localparam int CTRL_WAIT_LSB = 5;
    localparam int PAGE_INFO_BIT = 7;           // info_page_select
    localparam int PG_ROW_BIT   = 0;            // row_program_enable
    localparam int PG_MASS_BIT  = 1;
    localparam int PG_PAGE_BIT  = 2;
    localparam int ST_DONE_BIT  = 0;
    localparam int ST_RTO_BIT   = 1;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] LAST_COL    = 8'hFF;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic        req;    // Held until ack
        logic        we;
        logic [17:0] addr;   // Page, row, column
        logic [7:0]  wdata;
    } ofc_mem_req_t;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_PROG  = 4'b0100,
        ST_ERASE = 4'b1000
    } ofc_state_t;
endpackage

/* verilog/ofc_flash_ctrl.sv */
`timescale 1ns/1ps
module ofc_flash_ctrl #(
    parameter int PAGE_ERASE = ofc_pkg::PAGE_ERASE_CYC,
    parameter int MASS_ERASE = ofc_pkg::MASS_ERASE_CYC,
    parameter int ROW_TMO    = ofc_pkg::ROW_TMO_CYC
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [7:0]           i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic [31:0]               o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire ofc_pkg::ofc_mem_req_t i_mem,
    output logic                      o_mem_ack,
    output logic                      o_mem_wait,
    output logic [7:0]                o_mem_rdata,
    input  wire logic                 i_wp_n,
    output logic                      o_hv,
    output logic                      o_erase_done
);
    import ofc_pkg::*;

    // ****************************************
    // Storage and state
    // ****************************************
    logic [7:0]  main_mem [MAIN_BYTES];  // Main array [R1]
    logic [7:0]  info_mem [INFO_BYTES];  // Info page [R2]
    logic        wp_meta, wp_sync;       // Pin synchroniser
    logic [7:0]  ctrl;                   // Wait field, enable
    logic [7:0]  page;                   // Info bit, page
    logic [2:0]  row;
    logic [7:0]  col;
    logic [7:0]  data_q;                 // Last data byte
    logic        row_en;                 // row_program_enable
    logic [7:0]  prot;                   // Block protect bits
    logic        mass_pend, page_pend;   // Erase requests
    logic        done_f, rto_f;          // Sticky status
    ofc_state_t  state;
    logic [23:0] cnt;                    // Operation timer
    logic [17:0] tgt;                    // Target address
    logic        tgt_info, tgt_ok, tgt_mem;
    logic [7:0]  tgt_d;
    logic        apb_done, mw_done;      // Completion pulses
    logic        ers_mass, ers_info, ers_sw;
    logic [17:0] ers_ptr;                // Erase sweep index
    logic [23:0] row_tmr;                // Row mode time
    logic        mr_busy, mr_done;
    logic [2:0]  mr_cnt;
    logic [7:0]  mr_data;

    // ****************************************
    // Decode
    // ****************************************
    logic        apb_acc, apb_data, apb_wr, mapped;
    logic        mem_en, start_apb, start_mw, prog_fin, rto_hit;
    logic        row_end, mr_block;
    logic [17:0] port_addr, ers_last, ers_main;
    logic [2:0]  wait_n;
    assign apb_acc   = i_psel & i_penable;
    assign apb_data  = apb_acc & (i_paddr == REG_DATA);
    assign mapped    = (i_paddr[1:0] == 2'h0) & (i_paddr <= REG_PROT);
    assign apb_wr    = apb_acc & i_pwrite & o_pready;
    assign mem_en    = ctrl[CTRL_EN_BIT];
    assign wait_n    = ctrl[CTRL_WAIT_LSB +: 3];
    assign port_addr = {page[6:0], row, col};  // [R1]
    // Data port stalls until the engine answers [R9] [R11] [R20]
    assign o_pready  = apb_data ? apb_done : 1'b1;
    assign o_pslverr = apb_acc & ~mapped;
    assign start_apb = apb_data & ~apb_done & (state == ST_IDLE);
    assign start_mw  = i_mem.req & i_mem.we & ~mw_done & ~start_apb
                       & (state == ST_IDLE);
    assign prog_fin  = (state == ST_PROG) & (cnt == 24'h0);
    assign rto_hit   = o_hv & (row_tmr == 24'(ROW_TMO - 1));
    assign row_end   = o_hv & prog_fin & ~tgt_mem & (tgt[7:0] == LAST_COL);
    assign ers_last  = ers_mass ? 18'(MAIN_BYTES - 1)
                       : (ers_info ? 18'(INFO_BYTES - 1) : 18'(PAGE_BYTES - 1));
    assign ers_main  = ers_mass ? ers_ptr : {page[6:0], ers_ptr[10:0]};
    // Reads stall on erase or on the block being programmed [R20] [R22]
    assign mr_block  = (state == ST_ERASE) | ((state == ST_PROG) & ~tgt_info
                       & (tgt[17:15] == i_mem.addr[17:15]));
    assign o_mem_ack  = mr_done | mw_done;
    assign o_mem_wait = i_mem.req & ~o_mem_ack;
    assign o_erase_done = done_f;

    // Block protection, boot block also by pin [R3] [R4]
    function automatic logic blk_prot(input logic [17:0] a);
        blk_prot = prot[a[17:15]] | ((a[17:15] == 3'h0) & wp_sync);
    endfunction

    // ****************************************
    // Write-protect pin synchroniser
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_meta <= 1'b0;
            wp_sync <= 1'b0;
        end else begin
            wp_meta <= ~i_wp_n;
            wp_sync <= wp_meta;
        end
    end

    // ****************************************
    // Register writes and address pointer
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl   <= CTRL_RST;
            page   <= 8'h00;
            row    <= 3'h0;
            col    <= 8'h00;
            row_en <= 1'b0;
            prot   <= 8'h00;
        end else begin
            // Pointer steps after every data port access [R8]
            if (apb_data & apb_done) begin
                {page[6:0], row, col} <= port_addr + 18'h1;
            end else if (apb_wr) begin
                case (i_paddr)
                    REG_CTRL:  ctrl   <= i_pwdata[7:0];
                    REG_PAGE:  page   <= i_pwdata[7:0];
                    REG_ROW:   row    <= i_pwdata[2:0];
                    REG_COL:   col    <= i_pwdata[7:0];
                    REG_PROT:  prot   <= i_pwdata[7:0];
                    default:   ;
                endcase
            end
            // Row mode ends at last column or time-out [R12] [R14]
            if (row_end | rto_hit) begin
                row_en <= 1'b0;
            end else if (apb_wr & (i_paddr == REG_PGCTL)) begin
                row_en <= i_pwdata[PG_ROW_BIT];
            end
        end
    end

    // ****************************************
    // Erase requests and sticky status
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mass_pend <= 1'b0;
            page_pend <= 1'b0;
            done_f    <= 1'b0;
            rto_f     <= 1'b0;
        end else begin
            if (state == ST_ERASE) begin
                mass_pend <= 1'b0;
                page_pend <= 1'b0;
            end else if (apb_wr & (i_paddr == REG_PGCTL)) begin
                mass_pend <= mass_pend | i_pwdata[PG_MASS_BIT];
                page_pend <= page_pend | i_pwdata[PG_PAGE_BIT];
            end
            // Set wins over a write-one clear [R19]
            if ((state == ST_ERASE) & (cnt == 24'h0) & ers_sw) begin
                done_f <= 1'b1;
            end else if (apb_wr & (i_paddr == REG_STAT) & i_pwdata[ST_DONE_BIT]) begin
                done_f <= 1'b0;
            end
            if (rto_hit) begin
                rto_f <= 1'b1;  // [R14]
            end else if (apb_wr & (i_paddr == REG_STAT) & i_pwdata[ST_RTO_BIT]) begin
                rto_f <= 1'b0;
            end
        end
    end

    // ****************************************
    // Read data mux
    // ****************************************
    always_comb begin
        o_prdata = 32'h0;
        case (i_paddr)
            REG_CTRL:  o_prdata[7:0] = ctrl;
            REG_PAGE:  o_prdata[7:0] = page;
            REG_ROW:   o_prdata[2:0] = row;
            REG_COL:   o_prdata[7:0] = col;
            REG_DATA:  o_prdata[7:0] = data_q;
            REG_PGCTL: o_prdata[3:0] = {page_pend, mass_pend, row_en};
            REG_STAT:  o_prdata[3:0] = {o_hv, state != ST_IDLE, rto_f, done_f};
            REG_PROT:  o_prdata[7:0] = prot;
            default:   o_prdata = 32'h0;
        endcase
    end

    // ****************************************
    // Program, read and erase engine
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state    <= ST_IDLE;
            cnt      <= 24'h0;
            tgt      <= 18'h0;
            tgt_info <= 1'b0;
            tgt_ok   <= 1'b0;
            tgt_mem  <= 1'b0;
            tgt_d    <= 8'h00;
            apb_done <= 1'b0;
            mw_done  <= 1'b0;
            data_q   <= 8'h00;
            ers_mass <= 1'b0;
            ers_info <= 1'b0;
            ers_sw   <= 1'b0;
            ers_ptr  <= 18'h0;
        end else begin
            apb_done <= 1'b0;
            mw_done  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_apb) begin
                        // Data port goes to info page when selected [R6]
                        tgt      <= port_addr;
                        tgt_info <= page[PAGE_INFO_BIT];
                        tgt_mem  <= 1'b0;
                        tgt_d    <= i_pwdata[7:0];
                        tgt_ok   <= page[PAGE_INFO_BIT] | ~blk_prot(port_addr);
                        if (i_pwrite) begin
                            data_q <= i_pwdata[7:0];
                            state  <= ST_PROG;
                            // Row mode byte time is shorter [R11] [R13]
                            cnt <= row_en ? 24'(ROW_PROG_CYC - 1)
                                          : 24'(BYTE_PROG_CYC - 1);  // [R9]
                        end else begin
                            state <= ST_READ;
                            cnt   <= {21'h0, wait_n};  // [R7]
                        end
                    end else if (start_mw & ~mem_en) begin
                        mw_done <= 1'b1;
                    end else if (start_mw) begin
                        // One byte per memory write, never row mode [R10]
                        tgt      <= i_mem.addr;
                        tgt_info <= 1'b0;
                        tgt_mem  <= 1'b1;
                        tgt_d    <= i_mem.wdata;
                        tgt_ok   <= ~blk_prot(i_mem.addr);
                        state    <= ST_PROG;
                        cnt      <= 24'(BYTE_PROG_CYC - 1);
                    end else if (mass_pend | page_pend) begin
                        ers_mass <= mass_pend;
                        ers_info <= page[PAGE_INFO_BIT];
                        ers_sw   <= 1'b0;
                        ers_ptr  <= 18'h0;
                        state    <= ST_ERASE;
                        cnt <= mass_pend ? 24'(MASS_ERASE - 1)  // [R21]
                                         : 24'(PAGE_ERASE - 1);  // [R23]
                    end
                end
                ST_READ: begin
                    cnt <= cnt - 24'h1;
                    if (cnt == 24'h0) begin
                        data_q   <= tgt_info ? info_mem[tgt[8:0]] : main_mem[tgt];
                        apb_done <= 1'b1;  // [R8]
                        state    <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    cnt <= cnt - 24'h1;
                    // Wait drops the cycle after expiry or abort [R24] [R14]
                    if (prog_fin | rto_hit) begin
                        apb_done <= ~tgt_mem;
                        mw_done  <= tgt_mem;
                        state    <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    // Self-timed, data port stalls until it ends [R19] [R20]
                    if (cnt != 24'h0) begin
                        cnt <= cnt - 24'h1;
                    end
                    if (ers_ptr == ers_last) begin
                        ers_sw <= 1'b1;
                    end else begin
                        ers_ptr <= ers_ptr + 18'h1;
                    end
                    if ((cnt == 24'h0) & ers_sw) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Row high voltage and time-out timer
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hv    <= 1'b0;
            row_tmr <= 24'h0;
        end else begin
            if (row_end | rto_hit) begin
                o_hv <= 1'b0;  // [R12] [R14]
            end else if (start_apb & i_pwrite & row_en) begin
                o_hv <= 1'b1;  // [R11]
            end
            row_tmr <= o_hv ? row_tmr + 24'h1 : 24'h0;
        end
    end

    // ****************************************
    // Array write port
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (prog_fin & tgt_ok & ~rto_hit) begin
            if (tgt_info) begin
                info_mem[tgt[8:0]] <= tgt_d;
            end else begin
                main_mem[tgt] <= tgt_d;
            end
        end
        if ((state == ST_ERASE) & ~ers_sw) begin
            // Erase writes FFh, skipping protected blocks [R18] [R3]
            if (ers_mass | ~ers_info) begin
                if (~blk_prot(ers_main) & ~(~ers_mass & prot[page[6:4]])) begin
                    main_mem[ers_main] <= ERASED_BYTE;
                end
            end
            if (ers_info & (ers_ptr < 18'(INFO_BYTES))) begin
                info_mem[ers_ptr[8:0]] <= ERASED_BYTE;  // [R21] [R23]
            end
        end
    end

    // ****************************************
    // Memory-space read path
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mr_busy <= 1'b0;
            mr_done <= 1'b0;
            mr_cnt  <= 3'h0;
            mr_data <= 8'h00;
        end else begin
            mr_done <= 1'b0;
            if (!mr_busy) begin
                if (i_mem.req & ~i_mem.we & ~mr_done & ~mr_block) begin
                    mr_busy <= 1'b1;
                    mr_cnt  <= wait_n;  // [R5] [R7]
                end
            end else if (mr_cnt != 3'h0) begin
                mr_cnt <= mr_cnt - 3'h1;
            end else begin
                // Main array only; disabled space reads FFh [R5] [R6]
                mr_data <= mem_en ? main_mem[i_mem.addr] : ERASED_BYTE;
                mr_done <= 1'b1;
                mr_busy <= 1'b0;
            end
        end
    end
    assign o_mem_rdata = mr_data;

endmodule // ofc_flash_ctrl

/* test/ofc_flash_ctrl_monitor.sv */
`timescale 1ns/1ps
module ofc_flash_ctrl_mon (
    input wire logic                  i_sys_clk,
    input wire logic                  i_rst_b,
    input wire logic                  i_psel,
    input wire logic                  i_penable,
    input wire logic                  i_pwrite,
    input wire logic [7:0]            i_paddr,
    input wire logic [31:0]           i_pwdata,
    input wire logic                  o_pready,
    input wire logic                  o_pslverr,
    input wire ofc_pkg::ofc_mem_req_t i_mem,
    input wire logic                  o_mem_ack,
    input wire logic                  o_mem_wait,
    input wire logic [7:0]            o_mem_rdata,
    input wire logic                  o_hv,
    input wire logic                  o_erase_done
);
    import ofc_pkg::*;
    // ****************************************
    // Port relations
    // ****************************************
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    a_ack_pulse: assert property (o_mem_ack |=> !o_mem_ack) else $error("ack not a pulse");
    a_wait_stall: assert property (o_mem_wait == (i_mem.req && !o_mem_ack))
        else $error("wait does not track request");
    a_read_waits: assert property ($rose(i_mem.req) && !i_mem.we |-> !o_mem_ack [*6])
        else $error("memory read answered too soon");
    a_write_waits: assert property ($rose(i_mem.req) && i_mem.we |-> !o_mem_ack [*8])
        else $error("memory write answered too soon");
    a_port_read_wait: assert property ($rose(i_penable) && i_psel && i_paddr == REG_DATA
        |-> !o_pready [*5]) else $error("data port answered too soon");
    a_reg_ready: assert property (i_psel && i_penable && i_paddr != REG_DATA |-> o_pready)
        else $error("register access stalled");
    a_unmapped_err: assert property (i_psel && i_penable && i_paddr > REG_PROT |-> o_pslverr)
        else $error("unmapped access not refused");
    a_done_sticky: assert property (o_erase_done && !(i_psel && i_penable && i_pwrite
        && i_paddr == REG_STAT && i_pwdata[ST_DONE_BIT]) |=> o_erase_done)
        else $error("done status lost");
    a_hv_cause: assert property ($rose(o_hv) |->
        $past(i_psel && i_pwrite && i_paddr == REG_DATA))
        else $error("high voltage without port write");
    a_hv_release: assert property ($fell(o_hv) |->
        $past(i_psel && i_paddr == REG_DATA))
        else $error("high voltage dropped outside a byte");
    a_rdata_hold: assert property (!o_mem_ack |=> o_mem_ack || $stable(o_mem_rdata))
        else $error("read data moved without ack");
    c_erase: cover property (o_erase_done);
    c_row: cover property (o_hv);
    c_mem_write: cover property (o_mem_ack && i_mem.we);
endmodule // ofc_flash_ctrl_mon
bind ofc_flash_ctrl ofc_flash_ctrl_mon u_mon (.i_sys_clk, .i_rst_b, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_mem, .o_mem_ack, .o_mem_wait,
    .o_mem_rdata, .o_hv, .o_erase_done);

/* test/ofc_cpu_model.sv */
`timescale 1ns/1ps
module ofc_cpu_model (
    input  wire logic             i_sys_clk,
    input  wire logic             i_mem_ack,
    input  wire logic [7:0]       i_mem_rdata,
    output ofc_pkg::ofc_mem_req_t o_mem
);
    import ofc_pkg::*;
    // ****************************************
    // Processor memory cycles
    // ****************************************
    initial o_mem = '0;
    // One byte per cycle, request held until the ack edge
    task automatic access(input logic we, input logic [17:0] a, input logic [7:0] wd,
                          output logic [7:0] rd);
        @(posedge i_sys_clk);
        o_mem <= '{req: 1'b1, we: we, addr: a, wdata: wd};
        // Ack and read data are taken at the same rising edge
        do @(posedge i_sys_clk); while (i_mem_ack !== 1'b1);
        rd = i_mem_rdata;
        // Released lines show the inverse, never the old value
        o_mem <= '{req: 1'b0, we: ~we, addr: ~a, wdata: ~wd};
    endtask
endmodule // ofc_cpu_model

/* test/ofc_flash_ctrl_bench.sv */
`timescale 1ns/1ps
module ofc_flash_ctrl_bench;
    import ofc_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic                  clk, rst_b, psel, penable, pwrite, wp_n, err;
    logic                  pready, pslverr, mem_ack, mem_wait, hv, done;
    logic [7:0]            paddr, rb, b1, b2, mem_rdata;
    logic [31:0]           pwdata, prdata, q, seed;
    ofc_pkg::ofc_mem_req_t mem;
    integer                num_errors = 0, compares = 0, cyc = 0, t0;
    ofc_flash_ctrl #(.PAGE_ERASE(3000), .MASS_ERASE(300000), .ROW_TMO(5000)) DUT (
        .i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_mem(mem), .o_mem_ack(mem_ack),
        .o_mem_wait(mem_wait), .o_mem_rdata(mem_rdata), .i_wp_n(wp_n), .o_hv(hv),
        .o_erase_done(done));
    ofc_cpu_model cpu (.i_sys_clk(clk), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .o_mem(mem));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // APB transfer: held until pready at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ready and read data are taken at the same rising edge
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Page erase; a read of main page p[6:0] stalls until it ends
    task automatic erase(input logic [7:0] p);
        apb(1'b1, REG_PAGE, {24'h0, p});
        apb(1'b1, REG_PGCTL, 32'h4);
        t0 = cyc;
        cpu.access(1'b0, {p[6:0], 11'h000}, 8'h00, rb);
        chk(32'(rb), 32'(ERASED_BYTE));
        chk(32'(cyc - t0 > 2000), 32'h1);
        apb(1'b0, REG_STAT, 32'h0);
        chk(32'(q[ST_DONE_BIT]), 32'h1);
        apb(1'b1, REG_STAT, 32'h1);
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        wp_n = 1'b1;
        seed = xs(32'd40);
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h88);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(err), 32'h1);
        erase(8'd0);
        erase(8'd16);
        // Info page erase, then read back through the data port
        erase(8'h80);
        apb(1'b0, REG_DATA, 32'h0);
        chk(32'(q[7:0]), 32'(ERASED_BYTE));
        // Each byte is programmed once only since its erase
        apb(1'b1, REG_PAGE, 32'h0);
        apb(1'b1, REG_COL, 32'h0);
        t0 = cyc;
        apb(1'b1, REG_DATA, {24'h0, seed[7:0]});
        chk(32'(cyc - t0 >= BYTE_PROG_CYC), 32'h1);
        apb(1'b0, REG_COL, 32'h0);
        chk(q, 32'h1);
        cpu.access(1'b0, 18'h00000, 8'h00, rb);
        chk(32'(rb), 32'(seed[7:0]));
        cpu.access(1'b1, 18'h00002, seed[15:8], rb);
        apb(1'b1, REG_COL, 32'h2);
        apb(1'b0, REG_DATA, 32'h0);
        chk(32'(q[7:0]), 32'(seed[15:8]));
        // Block 1 protected: the write is refused
        apb(1'b1, REG_PROT, 32'h2);
        cpu.access(1'b1, 18'h08000, seed[23:16], rb);
        cpu.access(1'b0, 18'h08000, 8'h00, rb);
        chk(32'(rb), 32'(ERASED_BYTE));
        apb(1'b1, REG_PROT, 32'h0);
        // Pin guards the lowest block
        wp_n <= 1'b0;
        apb(1'b1, REG_COL, 32'h5);
        apb(1'b1, REG_DATA, {24'h0, seed[31:24]});
        apb(1'b1, REG_COL, 32'h5);
        apb(1'b0, REG_DATA, 32'h0);
        chk(32'(q[7:0]), 32'(ERASED_BYTE));
        wp_n <= 1'b1;
        // Row mode over the last two columns
        seed = xs(seed);
        b1 = seed[7:0];
        b2 = seed[15:8];
        apb(1'b0, REG_PGCTL, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, REG_PAGE, 32'd16);
        apb(1'b1, REG_COL, 32'd254);
        apb(1'b1, REG_PGCTL, 32'h1);
        t0 = cyc;
        apb(1'b1, REG_DATA, {24'h0, b1});
        chk(32'(cyc - t0 < BYTE_PROG_CYC), 32'h1);
        chk(32'(hv), 32'h1);
        apb(1'b1, REG_DATA, {24'h0, b2});
        chk(32'(hv), 32'h0);
        apb(1'b0, REG_PGCTL, 32'h0);
        chk(32'(q[PG_ROW_BIT]), 32'h0);
        apb(1'b1, REG_ROW, 32'h0);
        apb(1'b1, REG_COL, 32'd254);
        apb(1'b0, REG_DATA, 32'h0);
        chk(32'(q[7:0]), 32'(b1));
        apb(1'b0, REG_DATA, 32'h0);
        chk(32'(q[7:0]), 32'(b2));
        give_verdict();
    end
endmodule // ofc_flash_ctrl_bench
